/* rtl/mrs_checker.sv */
`timescale 1ns/1ps
module mrs_checker
    import mrs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // configuration
    input wire logic [7:0] node_addr_i,
    input wire logic float_ok_i,
    // received frame bytes, same clock
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_end_i,
    input wire logic rx_err_i,
    // parameter store access
    output logic par_we_o,
    output logic [13:0] par_addr_o,
    output logic [31:0] par_wdata_o,
    output logic par_wide_o,
    input wire logic par_wr_ok_i,
    // reply byte stream
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    output logic tx_last_o,
    // status
    output logic busy_o,
    output logic [7:0] wr_count_o
);
    typedef enum logic [2:0] {
        MRS_IDLE = 3'b000,
        MRS_RECV = 3'b001,
        MRS_CHECK = 3'b010,
        MRS_WRITE = 3'b011,
        MRS_WAIT = 3'b100,
        MRS_SEND = 3'b101,
        MRS_DROP = 3'b110
    } mrs_state_t;

    mrs_state_t state_ff, nxt_state;
    logic [15:0] crc_ff, nxt_crc;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [7:0] fc_ff, nxt_fc;
    logic [15:0] reg_addr_ff, nxt_reg_addr;
    logic [15:0] reg_num_ff, nxt_reg_num;
    logic [7:0] excode_ff, nxt_excode;
    logic [7:0] dly_ff, nxt_dly;
    logic [7:0] wcnt_ff, nxt_wcnt;
    logic [7:0] txi_ff, nxt_txi;
    logic stop_ff, nxt_stop;
    logic we_ff, nxt_we;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [47:0] hold_ff, nxt_hold;
    logic wide, fifo_in_ready, fifo_push;
    logic [7:0] fifo_in, tx_byte;
    logic [15:0] crc_rx_next, tx_crc_ff, nxt_tx_crc;

    // bit-serial CRC, lsb first, reflected polynomial of x16+x15+x2+1
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ MRS_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    assign crc_rx_next = crc_byte(crc_ff, rx_data_i);
    assign wide = reg_addr_ff[MRS_TYPE_LO_BIT];

    always_comb begin
        nxt_state = state_ff;
        nxt_crc = crc_ff;
        nxt_cnt = cnt_ff;
        nxt_fc = fc_ff;
        nxt_reg_addr = reg_addr_ff;
        nxt_reg_num = reg_num_ff;
        nxt_excode = excode_ff;
        nxt_dly = dly_ff;
        nxt_wcnt = wcnt_ff;
        nxt_txi = txi_ff;
        nxt_stop = stop_ff;
        nxt_we = 1'b0;
        nxt_wdata = wdata_ff;
        nxt_hold = hold_ff;
        nxt_tx_crc = tx_crc_ff;
        case (state_ff)
            MRS_IDLE, MRS_RECV: begin
                if (rx_err_i) begin
                    nxt_state = MRS_DROP;
                end else if (rx_valid_i) begin
                    nxt_state = MRS_RECV;
                    nxt_crc = (state_ff == MRS_IDLE) ? crc_byte(MRS_CRC_INIT, rx_data_i)
                        : crc_rx_next;
                    nxt_cnt = (state_ff == MRS_IDLE) ? 8'h01 : cnt_ff + 8'h01;
                    if (state_ff == MRS_IDLE && rx_data_i != node_addr_i
                        && rx_data_i != MRS_BCAST_ADDR) nxt_state = MRS_DROP;
                    // count and code of the last frame linger, so fields are taken in recv only
                    if (state_ff == MRS_RECV) begin
                        if (cnt_ff == 8'h01) nxt_fc = rx_data_i;
                        if (cnt_ff == 8'h02) nxt_reg_addr[15:8] = rx_data_i;
                        if (cnt_ff == 8'h03) nxt_reg_addr[7:0] = rx_data_i;
                        if (cnt_ff == 8'h04) nxt_reg_num[15:8] = rx_data_i;
                        if (cnt_ff == 8'h05) nxt_reg_num[7:0] = rx_data_i;
                        // last six bytes kept: the payload value sits just ahead of the crc
                        if (cnt_ff >= 8'h07) nxt_hold = {hold_ff[39:0], rx_data_i};
                        // oversized block write is thrown away silently
                        if ((fc_ff == MRS_FC_WRITE || fc_ff == MRS_FC_RDWR)
                            && cnt_ff > MRS_MAX_BYTES) nxt_state = MRS_DROP;
                    end
                end else if (rx_end_i && state_ff == MRS_RECV) begin
                    // residue zero after both crc bytes means a clean frame
                    if (crc_ff != 16'h0000 || cnt_ff < 8'(MRS_HDR_BYTES + 2)) begin
                        nxt_state = MRS_IDLE;
                    end else begin
                        nxt_state = MRS_CHECK;
                    end
                    nxt_dly = 8'h00;
                end
            end
            MRS_CHECK: begin
                nxt_excode = 8'h00;
                nxt_wcnt = 8'h00;
                nxt_stop = 1'b0;
                nxt_txi = 8'h00;
                nxt_dly = dly_ff + 8'h01;
                if (fc_ff != MRS_FC_READ && fc_ff != MRS_FC_WRITE
                    && fc_ff != MRS_FC_RDWR) begin
                    nxt_excode = MRS_EXC_BAD_FC;
                end else if (reg_addr_ff[13:0] > MRS_PARAM_MAX
                    || reg_num_ff > MRS_MAX_READ_REGS) begin
                    nxt_excode = MRS_EXC_BAD_ADDR;
                end else if (wide && reg_num_ff[0]) begin
                    nxt_excode = MRS_EXC_BAD_ADDR;
                end else if (reg_addr_ff[15:14] == MRS_TYPE_FLOAT && !float_ok_i) begin
                    nxt_excode = MRS_EXC_OVER_RANGE;
                end
                if (nxt_excode == 8'h00 && fc_ff != MRS_FC_READ) begin
                    nxt_we = 1'b1;
                    // the data path stands in for payload bytes; one value per frame, whatever the register count
                    nxt_wdata = wide ? hold_ff[47:16]
                        : {{16{hold_ff[31]}}, hold_ff[31:16]};
                    nxt_state = MRS_WRITE;
                end else begin
                    nxt_state = MRS_WAIT;
                end
            end
            MRS_WRITE: begin
                nxt_dly = dly_ff + 8'h01;
                if (!par_wr_ok_i || stop_ff) begin
                    nxt_stop = 1'b1;
                end else begin
                    nxt_wcnt = wcnt_ff + 8'h01;
                end
                // a refused store write raises no exception: fc23 never reports it, fc16 only through the count
                nxt_state = MRS_WAIT;
            end
            MRS_WAIT: begin
                nxt_dly = (dly_ff < MRS_MIN_RESP_CYC) ? dly_ff + 8'h01 : dly_ff;
                nxt_tx_crc = MRS_CRC_INIT;
                if (dly_ff >= MRS_MIN_RESP_CYC) nxt_state = MRS_SEND;
            end
            MRS_SEND: begin
                if (fifo_in_ready) begin
                    nxt_txi = txi_ff + 8'h01;
                    if (txi_ff < 8'(MRS_EXC_LEN - 2)) nxt_tx_crc = crc_byte(tx_crc_ff, tx_byte);
                    if (txi_ff == 8'(MRS_EXC_LEN - 1)) nxt_state = MRS_IDLE;
                end
            end
            MRS_DROP: begin
                if (rx_end_i) nxt_state = MRS_IDLE;
            end
            default: nxt_state = MRS_IDLE;
        endcase
    end

    // reply: exception or short write/read acknowledgement of same five-byte shape
    always_comb begin
        case (txi_ff)
            8'h00: tx_byte = node_addr_i;
            8'h01: tx_byte = (excode_ff != 8'h00) ? (fc_ff | MRS_EXC_FLAG) : fc_ff;
            // only fc16 shows its write count; fc23 gives the read byte count whatever the store did
            8'h02: tx_byte = (excode_ff != 8'h00) ? excode_ff
                : (fc_ff == MRS_FC_WRITE) ? wcnt_ff : {reg_num_ff[6:0], 1'b0};
            8'h03: tx_byte = tx_crc_ff[7:0];
            default: tx_byte = tx_crc_ff[15:8];
        endcase
    end
    assign fifo_push = (state_ff == MRS_SEND);
    assign fifo_in = tx_byte;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= MRS_IDLE;
            crc_ff <= MRS_CRC_INIT;
            cnt_ff <= '0;
            fc_ff <= '0;
            reg_addr_ff <= '0;
            reg_num_ff <= '0;
            excode_ff <= '0;
            dly_ff <= '0;
            wcnt_ff <= '0;
            txi_ff <= '0;
            stop_ff <= 1'b0;
            we_ff <= 1'b0;
            wdata_ff <= '0;
            hold_ff <= '0;
            tx_crc_ff <= MRS_CRC_INIT;
        end else begin
            state_ff <= nxt_state;
            crc_ff <= nxt_crc;
            cnt_ff <= nxt_cnt;
            fc_ff <= nxt_fc;
            reg_addr_ff <= nxt_reg_addr;
            reg_num_ff <= nxt_reg_num;
            excode_ff <= nxt_excode;
            dly_ff <= nxt_dly;
            wcnt_ff <= nxt_wcnt;
            txi_ff <= nxt_txi;
            stop_ff <= nxt_stop;
            we_ff <= nxt_we;
            wdata_ff <= nxt_wdata;
            hold_ff <= nxt_hold;
            tx_crc_ff <= nxt_tx_crc;
        end
    end

    logic f_valid;
    logic [7:0] f_data;
    logic out_valid_ff, out_last_ff, busy_ff, wide_ff;
    logic [7:0] out_data_ff, wrc_ff;
    logic [13:0] paddr_ff;
    logic [2:0] sent_ff;

    mrs_fifo #(.WIDTH(MRS_FIFO_WIDTH), .DEPTH(MRS_FIFO_DEPTH)) u_fifo (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .flush_i(1'b0),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(f_valid),
        .out_ready_i(tx_ready_i || !out_valid_ff),
        .out_data_o(f_data)
    );

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
            out_last_ff <= 1'b0;
            sent_ff <= '0;
            busy_ff <= 1'b0;
            paddr_ff <= '0;
            wide_ff <= 1'b0;
            wrc_ff <= '0;
        end else begin
            if (tx_ready_i || !out_valid_ff) begin
                out_valid_ff <= f_valid;
                out_data_ff <= f_data;
                out_last_ff <= f_valid && sent_ff == 3'(MRS_EXC_LEN - 1);
                if (f_valid) sent_ff <= (sent_ff == 3'(MRS_EXC_LEN - 1)) ? '0 : sent_ff + 3'h1;
            end
            busy_ff <= nxt_state != MRS_IDLE;
            paddr_ff <= reg_addr_ff[13:0];
            wide_ff <= wide;
            wrc_ff <= wcnt_ff;
        end
    end

    assign par_we_o = we_ff;
    assign par_addr_o = paddr_ff;
    assign par_wdata_o = wdata_ff;
    assign par_wide_o = wide_ff;
    assign tx_valid_o = out_valid_ff;
    assign tx_data_o = out_data_ff;
    assign tx_last_o = out_last_ff;
    assign busy_o = busy_ff;
    assign wr_count_o = wrc_ff;

    chk_bad_crc_silent: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state_ff == MRS_RECV && rx_end_i && crc_ff != 16'h0000 |=> state_ff == MRS_IDLE)
        else $error("bad crc frame not dropped");
    chk_resp_delay: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state_ff == MRS_SEND && $past(state_ff) == MRS_WAIT |-> $past(dly_ff) >= MRS_MIN_RESP_CYC)
        else $error("reply before minimum delay");
    chk_exc_flag: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state_ff == MRS_SEND && txi_ff == 8'h01 && excode_ff != 8'h00 |-> tx_byte[7])
        else $error("exception fc lacks bit 7");
    chk_odd_wide: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state_ff == MRS_CHECK && fc_ff == MRS_FC_READ && wide && reg_num_ff[0]
        && reg_addr_ff[13:0] <= MRS_PARAM_MAX && reg_num_ff <= MRS_MAX_READ_REGS
        |=> excode_ff == MRS_EXC_BAD_ADDR)
        else $error("odd wide count not code 2");
    chk_bad_fc: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state_ff == MRS_CHECK && fc_ff == 8'h05 |=> excode_ff == MRS_EXC_BAD_FC)
        else $error("bad function not code 1");
    chk_sign_ext: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        we_ff && !wide_ff |-> wdata_ff[31:16] == {16{wdata_ff[15]}})
        else $error("narrow write not sign extended");
    chk_block_stop: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state_ff == MRS_WRITE && !par_wr_ok_i |=> stop_ff && wcnt_ff == $past(wcnt_ff))
        else $error("failed write counted");
    chk_drop_len: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        state_ff == MRS_RECV && rx_valid_i && !rx_err_i && fc_ff == MRS_FC_WRITE
        && cnt_ff > MRS_MAX_BYTES |=> state_ff == MRS_DROP)
        else $error("oversized write kept");
endmodule

/* rtl/mrs_fifo.sv */
`timescale 1ns/1ps
module mrs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic flush_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic push, pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_ff != rd_ff;
    assign out_data_o = mem[rd_ff[AW-1:0]];

    always_comb begin
        nxt_wr = flush_i ? '0 : wr_ff + (AW+1)'(push);
        nxt_rd = flush_i ? '0 : rd_ff + (AW+1)'(pop);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_data_i;
        end
    end
endmodule

/* rtl/mrs_pkg.sv */
package mrs_pkg;
    localparam logic [15:0] MRS_CRC_INIT = 16'hFFFF;
    localparam logic [15:0] MRS_CRC_POLY = 16'hA001;
    localparam logic [7:0] MRS_FC_READ = 8'h03;
    localparam logic [7:0] MRS_FC_WRITE = 8'h10;
    localparam logic [7:0] MRS_FC_RDWR = 8'h17;
    localparam logic [7:0] MRS_EXC_FLAG = 8'h80;
    localparam logic [7:0] MRS_EXC_BAD_FC = 8'h01;
    localparam logic [7:0] MRS_EXC_BAD_ADDR = 8'h02;
    localparam logic [7:0] MRS_EXC_OVER_RANGE = 8'h03;
    localparam logic [7:0] MRS_BCAST_ADDR = 8'h00;
    localparam int MRS_TYPE_HI_BIT = 15;
    localparam int MRS_TYPE_LO_BIT = 14;
    localparam logic [1:0] MRS_TYPE_INT16 = 2'h0;
    localparam logic [1:0] MRS_TYPE_INT32 = 2'h1;
    localparam logic [1:0] MRS_TYPE_FLOAT = 2'h2;
    localparam logic [13:0] MRS_PARAM_MAX = 14'h0BB7;
    localparam logic [7:0] MRS_MAX_BYTES = 8'h20;
    localparam logic [15:0] MRS_MAX_READ_REGS = 16'h0010;
    localparam int MRS_MIN_RESP_NS = 2000;
    localparam int MRS_CLK_NS = 20;
    localparam logic [7:0] MRS_MIN_RESP_CYC =
        8'((MRS_MIN_RESP_NS + MRS_CLK_NS - 1) / MRS_CLK_NS);
    localparam int MRS_FIFO_WIDTH = 8;
    localparam int MRS_FIFO_DEPTH = 16;
    localparam int MRS_HDR_BYTES = 6;
    localparam int MRS_EXC_LEN = 5;
endpackage

/* sim/mrs_master.sv */
`timescale 1ns/1ps
module mrs_master
    import mrs_pkg::*;
(
    input wire logic core_clk_i,
    // request byte stream towards the slave
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_end_o,
    output logic rx_err_o,
    // reply byte stream from the slave
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_last_i,
    output logic tx_ready_o
);
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'hA5;
        rx_end_o = 1'b0;
        rx_err_o = 1'b0;
        tx_ready_o = 1'b0;
    end

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = MRS_CRC_INIT;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ MRS_CRC_POLY) : (c >> 1);
            end
        end
        return c;
    endfunction

    // corrupt flips bit 0 of the check value; err flags a framing error just before the end
    task automatic send(input logic [7:0] q[$], input bit corrupt, input bit err);
        logic [15:0] c;
        c = crc16(q);
        if (corrupt) begin
            c = c ^ 16'h0001;
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            @(negedge core_clk_i);
            rx_valid_o = 1'b1;
            rx_data_o = q[i];
            @(negedge core_clk_i);
            rx_valid_o = 1'b0;
            rx_data_o = ~q[i];
        end
        @(negedge core_clk_i);
        rx_err_o = err;
        @(negedge core_clk_i);
        rx_err_o = 1'b0;
        rx_end_o = 1'b1;
        @(negedge core_clk_i);
        rx_end_o = 1'b0;
    endtask

    // ready stalls every other cycle; a missing reply ends by timeout
    task automatic recv(output logic [7:0] r[$], output int lat, input int lim);
        logic v, l;
        logic [7:0] d;
        r = {};
        lat = -1;
        for (int n = 0; n < lim; n++) begin
            @(negedge core_clk_i);
            tx_ready_o = n[0];
            // reply lines move on rising edges, so the falling edge sees them settled
            v = tx_valid_i;
            d = tx_data_i;
            l = tx_last_i;
            @(posedge core_clk_i);
            if (v === 1'b1 && lat < 0) begin
                lat = n;
            end
            if (v === 1'b1 && tx_ready_o) begin
                r.push_back(d);
                if (l === 1'b1) begin
                    break;
                end
            end
        end
        @(negedge core_clk_i);
        tx_ready_o = 1'b0;
        repeat (20) @(negedge core_clk_i);
    endtask
endmodule

/* sim/mrs_tb.sv */
`timescale 1ns/1ps
module tb;
    import mrs_pkg::*;
    localparam logic [7:0] NODE = 8'h08;
    logic core_clk_i, resetn_i, float_ok, wr_ok, rx_valid, rx_end, rx_err;
    logic [7:0] rx_data, tx_data, wr_count;
    logic tx_valid, tx_ready, tx_last, busy, par_we, par_wide;
    logic [13:0] par_addr;
    logic [31:0] par_wdata;
    logic [7:0] rep[$];
    logic [7:0] q[$];
    logic [15:0] c;
    int lat, miscompares, comparisons, we_cnt;

    mrs_checker uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .node_addr_i(NODE),
        .float_ok_i(float_ok), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
        .rx_end_i(rx_end), .rx_err_i(rx_err), .par_we_o(par_we), .par_addr_o(par_addr),
        .par_wdata_o(par_wdata), .par_wide_o(par_wide), .par_wr_ok_i(wr_ok),
        .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
        .tx_last_o(tx_last), .busy_o(busy), .wr_count_o(wr_count));
    mrs_master mst (.core_clk_i(core_clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .rx_end_o(rx_end), .rx_err_o(rx_err), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_last_i(tx_last), .tx_ready_o(tx_ready));

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    // store stand-in: counts write pulses, looked at away from the launching edge
    always @(negedge core_clk_i) begin
        if (par_we === 1'b1) begin
            we_cnt++;
        end
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic exch(input bit corrupt, input bit err, input int lim);
        mst.send(q, corrupt, err);
        mst.recv(rep, lat, lim);
    endtask

    task automatic expect_exc(logic [7:0] fc, logic [7:0] code);
        exch(1'b0, 1'b0, 400);
        check("exc_len", rep.size(), MRS_EXC_LEN);
        while (rep.size() < 5) rep.push_back(8'h00);
        c = mst.crc16(rep[0:2]);
        check("exc_node", rep[0], NODE);
        check("exc_fc", rep[1], fc | MRS_EXC_FLAG);
        check("exc_code", rep[2], code);
        check("crc_lo", rep[3], c[7:0]);
        check("crc_hi", rep[4], c[15:8]);
        check("resp_delay", 32'(lat + 1 >= int'(MRS_MIN_RESP_CYC)), 1);
    endtask

    task automatic t_exceptions();
        q = {NODE, 8'h05, 8'h00, 8'h01, 8'h00, 8'h01};
        expect_exc(8'h05, MRS_EXC_BAD_FC);
        q = {NODE, MRS_FC_READ, 8'h00, 8'h01, 8'h00, 8'h11};
        expect_exc(MRS_FC_READ, MRS_EXC_BAD_ADDR);
        q = {NODE, MRS_FC_READ, 8'h0B, 8'hB8, 8'h00, 8'h01};
        expect_exc(MRS_FC_READ, MRS_EXC_BAD_ADDR);
        q = {NODE, MRS_FC_READ, 8'h40, 8'h7F, 8'h00, 8'h01};
        expect_exc(MRS_FC_READ, MRS_EXC_BAD_ADDR);
        float_ok = 1'b0;
        q = {NODE, MRS_FC_READ, 8'h80, 8'h01, 8'h00, 8'h02};
        expect_exc(MRS_FC_READ, MRS_EXC_OVER_RANGE);
        float_ok = 1'b1;
        exch(1'b0, 1'b0, 400);
        check("float_ok_fc", rep.size() > 1 ? rep[1] : 8'hFF, MRS_FC_READ);
        $display("test exceptions done");
    endtask

    task automatic t_silent();
        for (int k = 0; k < 4; k++) begin
            q = {(k == 2) ? 8'h09 : NODE, MRS_FC_READ, 8'h00, 8'h01, 8'h00, 8'h01};
            if (k == 3) begin
                q = {NODE, MRS_FC_WRITE, 8'h00, 8'h7F, 8'h00, 8'h11, 8'h22};
                repeat (34) q.push_back(8'h00);
            end
            exch(k == 0, k == 1, 300);
            check("silent_len", rep.size(), 0);
            check("silent_busy", busy, 1'b0);
        end
        $display("test silent done");
    endtask

    // one single-value block write; reply byte 2 carries the successful count
    task automatic wr(logic [15:0] a, logic [7:0] n, logic [31:0] d, bit ok,
                      logic [31:0] exp, logic [7:0] cnt);
        q = {NODE, MRS_FC_WRITE, a[15:8], a[7:0], 8'h00, n, 8'(2 * n)};
        if (n == 8'h02) begin
            q.push_back(d[31:24]);
            q.push_back(d[23:16]);
        end
        q.push_back(d[15:8]);
        q.push_back(d[7:0]);
        wr_ok = ok;
        we_cnt = 0;
        exch(1'b0, 1'b0, 400);
        check("wr_pulses", we_cnt, 1);
        check("wr_data", par_wdata, exp);
        check("wr_addr", par_addr, a[13:0]);
        check("wr_wide", par_wide, a[14]);
        check("wr_fc", rep.size() > 2 ? rep[1] : 8'hFF, MRS_FC_WRITE);
        check("wr_cnt", rep.size() > 2 ? rep[2] : 8'hFF, cnt);
        check("wr_count", wr_count, cnt);
    endtask

    task automatic t_writes();
        wr(16'h007F, 8'h01, 32'h0000ABCD, 1'b1, 32'hFFFFABCD, 8'h01);
        wr(16'h007F, 8'h01, 32'h00001234, 1'b1, 32'h00001234, 8'h01);
        wr(16'h407F, 8'h02, 32'h00001234, 1'b1, 32'h00001234, 8'h01);
        wr(16'h4080, 8'h02, 32'h00000123, 1'b1, 32'h00000123, 8'h01);
        wr(16'h0080, 8'h01, 32'h00007FFF, 1'b0, 32'h00007FFF, 8'h00);
        wr_ok = 1'b0;
        q = {NODE, MRS_FC_RDWR, 8'h00, 8'h7F, 8'h00, 8'h01, 8'h00, 8'h80, 8'h00, 8'h01,
             8'h02, 8'h7F, 8'hFF};
        exch(1'b0, 1'b0, 400);
        check("rdwr_fc", rep.size() > 1 ? rep[1] : 8'hFF, MRS_FC_RDWR);
        check("rdwr_len", rep.size() > 2 ? rep[2] : 8'hFF, 8'h02);
        wr_ok = 1'b1;
        $display("test writes done");
    endtask

    initial begin
        miscompares = 0;
        comparisons = 0;
        we_cnt = 0;
        float_ok = 1'b1;
        wr_ok = 1'b1;
        resetn_i = 1'b0;
        repeat (6) @(negedge core_clk_i);
        resetn_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        t_exceptions();
        t_silent();
        t_writes();
        give_verdict();
    end
endmodule
